//--- design/i2cp_pkg.sv
package i2cp_pkg;
   // Core clock and pin filter timing
   localparam int CLK_NS = 50;
   localparam int GLITCH_NS = 50;
   localparam int GLITCH_CYC_I = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] GLITCH_CYC = 3'(GLITCH_CYC_I);
   // Host bit timing: four quarters per serial clock period
   localparam int QTR_NS = 250;
   localparam int QTR_CYC_I = QTR_NS / CLK_NS;
   localparam logic [3:0] QTR_LAST = 4'(QTR_CYC_I - 1);
   // Byte framing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic RW_WRITE = 1'b0;
   localparam logic RW_READ = 1'b1;
   // Device byte positions inside a transfer
   localparam logic [1:0] BI_DEV = 2'h0;
   localparam logic [1:0] BI_HI = 2'h1;
   localparam logic [1:0] BI_LO = 2'h2;
   localparam logic [1:0] BI_DATA = 2'h3;
   // Host byte sequence positions
   localparam logic [2:0] HB_DEVW = 3'h0;
   localparam logic [2:0] HB_HI = 3'h1;
   localparam logic [2:0] HB_LO = 3'h2;
   localparam logic [2:0] HB_DATA = 3'h3;
   localparam logic [2:0] HB_DEVR = 3'h4;
   // Quarter positions within a bit
   localparam logic [1:0] Q_FALL = 2'h0;
   localparam logic [1:0] Q_DRIVE = 2'h1;
   localparam logic [1:0] Q_RISE = 2'h2;
   localparam logic [1:0] Q_SAMPLE = 2'h3;
   // Widths, depth and default target address (address value arbitrary)
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam logic [6:0] DEV_ADDR = 7'h2a;
endpackage : i2cp_pkg

//--- design/i2cp_if.sv
`timescale 1ns/1ns
interface i2cp_if;
   logic scl;          // Serial clock, driven by host only
   logic host_sda_o;   // Host data value
   logic host_sda_oe;  // Host drives data line
   logic dev_sda_o;    // Device data value
   logic dev_sda_oe;   // Device drives data line
   logic sda_line;     // Resolved wired-and data line
   // Open-drain resolution with pull-up
   assign sda_line = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);
   modport device(input scl, input sda_line, output dev_sda_o, output dev_sda_oe);
   modport host(output scl, output host_sda_o, output host_sda_oe, input sda_line);
endinterface : i2cp_if

//--- design/i2cp_dev.sv
`timescale 1ns/1ns
module i2cp_fifo #(
   parameter int W = 24,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];  // Storage
   logic [AW-1:0] wp_reg;      // Write pointer
   logic [AW-1:0] rp_reg;      // Read pointer
   logic [AW:0] cnt_reg;       // Fill level
   logic [AW:0] cnt_next;
   wire push_w = in_valid_i && in_ready_o;
   wire pop_w = out_valid_o && out_ready_i;
   assign cnt_next = cnt_reg + (AW+1)'(push_w) - (AW+1)'(pop_w);
   assign out_data_o = mem[rp_reg];
   // Pointers and registered flags
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end
      else
      begin
         wp_reg <= wp_reg + AW'(push_w);
         rp_reg <= rp_reg + AW'(pop_w);
         cnt_reg <= cnt_next;
         in_ready_o <= cnt_next != (AW+1)'(DEPTH);
         out_valid_o <= cnt_next != '0;
      end
   end
   // Storage write
   always_ff @(posedge clk_i)
   begin
      if (push_w)
         mem[wp_reg] <= in_data_i;
   end
endmodule : i2cp_fifo

module i2cp_dev #(
   parameter logic [6:0] OWN_ADDR = i2cp_pkg::DEV_ADDR,
   parameter int DEPTH = i2cp_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // Bus side
   i2cp_if.device bus_if,
   // Register write stream
   output logic wr_valid_o,
   input wire logic wr_ready_i,
   output logic [i2cp_pkg::ADDR_W-1:0] wr_addr_o,
   output logic [i2cp_pkg::DATA_W-1:0] wr_data_o,
   // Register read lookup
   output logic [i2cp_pkg::ADDR_W-1:0] rd_addr_o,
   input wire logic [i2cp_pkg::DATA_W-1:0] rd_data_i
);
   import i2cp_pkg::*;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RX = 5'h02,
      ST_ACK = 5'h04,
      ST_TX = 5'h08,
      ST_MACK = 5'h10
   } i2cp_dst_e;
   i2cp_dst_e st_reg, st_next;   // Framing state
   logic [1:0] s1_reg, s2_reg;   // Line synchronisers, bit1 clock, bit0 data
   logic [1:0] filt_w;           // Filtered lines
   logic [1:0] prev_reg;         // Filtered lines one cycle ago
   logic [3:0] bit_reg, bit_next;
   logic [1:0] bidx_reg, bidx_next;
   logic rw_reg, rw_next;
   logic [7:0] sh_reg, sh_next;
   logic [7:0] hi_reg, hi_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic oe_reg, oe_next;
   logic ack_reg, ack_next;
   logic push_w;
   logic fifo_rdy_w;
   // Two-flop synchronisers; s1 feeds only s2
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s1_reg <= 2'h3;
         s2_reg <= 2'h3;
      end
      else
      begin
         s1_reg <= {bus_if.scl, bus_if.sda_line};
         s2_reg <= s1_reg;
      end
   end
   // Glitch filter: a change must persist before it is taken
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_filt
         logic [2:0] cnt_reg;  // Cycles the new level has stood
         logic lvl_reg;        // Accepted level
         always_ff @(posedge ref_clk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
            begin
               cnt_reg <= '0;
               lvl_reg <= 1'b1;
            end
            else if (s2_reg[g] == lvl_reg)
               cnt_reg <= '0;
            else if (cnt_reg == GLITCH_CYC)
            begin
               lvl_reg <= s2_reg[g];
               cnt_reg <= '0;
            end
            else
               cnt_reg <= cnt_reg + 3'h1;
         end
         assign filt_w[g] = lvl_reg;
      end
   endgenerate
   // Bus events
   wire scl_w = filt_w[1];
   wire sda_w = filt_w[0];
   wire rise_w = scl_w && !prev_reg[1];
   wire fall_w = !scl_w && prev_reg[1];
   wire start_w = scl_w && prev_reg[1] && prev_reg[0] && !sda_w;
   wire stop_w = scl_w && prev_reg[1] && !prev_reg[0] && sda_w;
   wire full_w = bit_reg == BITS_PER_BYTE;
   // Next state of the framing engine
   always_comb
   begin
      st_next = st_reg;
      bit_next = bit_reg;
      bidx_next = bidx_reg;
      rw_next = rw_reg;
      sh_next = sh_reg;
      hi_next = hi_reg;
      addr_next = addr_reg;
      oe_next = oe_reg;
      ack_next = ack_reg;
      push_w = 1'b0;
      if (start_w)
      begin
         // Restart framing, partial byte dropped
         st_next = ST_RX;
         bit_next = '0;
         bidx_next = BI_DEV;
         oe_next = 1'b0;
      end
      else if (stop_w)
      begin
         // Stop ends any transfer
         st_next = ST_IDLE;
         oe_next = 1'b0;
      end
      else
      begin
         unique case (st_reg)
            ST_IDLE: ;  // Wait for start, line left alone
            ST_RX:
            begin
               if (rise_w && !full_w)
               begin
                  // Sample on rising clock, MSB first
                  sh_next = {sh_reg[6:0], sda_w};
                  bit_next = bit_reg + 4'h1;
               end
               else if (fall_w && full_w)
               begin
                  // Decide acknowledge after eighth bit
                  st_next = ST_ACK;
                  ack_next = 1'b1;
                  unique case (bidx_reg)
                     BI_DEV:
                     begin
                        ack_next = sh_reg[7:1] == OWN_ADDR;
                        rw_next = sh_reg[0];
                        if (sh_reg[7:1] != OWN_ADDR)
                           st_next = ST_IDLE;
                     end
                     BI_HI: hi_next = sh_reg;
                     BI_LO: addr_next = {hi_reg, sh_reg};
                     BI_DATA:
                     begin
                        // Store byte, nack when buffer full
                        ack_next = fifo_rdy_w;
                        push_w = fifo_rdy_w;
                        addr_next = addr_reg + ADDR_W'(fifo_rdy_w);
                     end
                  endcase
                  oe_next = ack_next && (st_next == ST_ACK);
               end
            end
            ST_ACK:
            begin
               if (fall_w)
               begin
                  // Ack slot over
                  oe_next = 1'b0;
                  bit_next = '0;
                  bidx_next = (bidx_reg == BI_DATA) ? BI_DATA : bidx_reg + 2'h1;
                  if (!ack_reg)
                     st_next = ST_IDLE;
                  else if (rw_reg == RW_READ && bidx_reg == BI_DEV)
                  begin
                     // Read data straight after address ack
                     st_next = ST_TX;
                     sh_next = rd_data_i;
                     oe_next = !rd_data_i[7];
                  end
                  else
                     st_next = ST_RX;
               end
            end
            ST_TX:
            begin
               if (rise_w)
                  bit_next = bit_reg + 4'h1;
               else if (fall_w && full_w)
               begin
                  // Release for master ack
                  oe_next = 1'b0;
                  st_next = ST_MACK;
                  addr_next = addr_reg + 16'h0001;
               end
               else if (fall_w)
               begin
                  // Next bit changed only while clock low
                  sh_next = {sh_reg[6:0], 1'b0};
                  oe_next = !sh_reg[6];
               end
            end
            ST_MACK:
            begin
               if (rise_w)
                  ack_next = !sda_w;
               else if (fall_w && ack_reg)
               begin
                  // Master wants more
                  st_next = ST_TX;
                  bit_next = '0;
                  sh_next = rd_data_i;
                  oe_next = !rd_data_i[7];
               end
               else if (fall_w)
                  st_next = ST_IDLE;
            end
         endcase
      end
   end
   // State registers
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_reg <= ST_IDLE;
         prev_reg <= 2'h3;
         bit_reg <= '0;
         bidx_reg <= BI_DEV;
         rw_reg <= RW_WRITE;
         sh_reg <= '0;
         hi_reg <= '0;
         addr_reg <= '0;
         oe_reg <= 1'b0;
         ack_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         prev_reg <= filt_w;
         bit_reg <= bit_next;
         bidx_reg <= bidx_next;
         rw_reg <= rw_next;
         sh_reg <= sh_next;
         hi_reg <= hi_next;
         addr_reg <= addr_next;
         oe_reg <= oe_next;
         ack_reg <= ack_next;
      end
   end
   // Pin drive: data only, clock is never driven
   assign bus_if.dev_sda_o = 1'b0;
   assign bus_if.dev_sda_oe = oe_reg;
   assign rd_addr_o = addr_reg;
   // Write buffer between bus and register user
   i2cp_fifo #(.W(ADDR_W + DATA_W), .DEPTH(DEPTH)) u_fifo (
      .clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(push_w),
      .in_ready_o(fifo_rdy_w),
      .in_data_i({addr_reg, sh_reg}),
      .out_valid_o(wr_valid_o),
      .out_ready_i(wr_ready_i),
      .out_data_o({wr_addr_o, wr_data_o})
   );
endmodule : i2cp_dev

//--- design/i2cp_host.sv
`timescale 1ns/1ns
module i2cp_host (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // Bus side
   i2cp_if.host bus_if,
   // Command
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic cmd_rd_i,
   input wire logic [6:0] cmd_dev_i,
   input wire logic [i2cp_pkg::ADDR_W-1:0] cmd_addr_i,
   input wire logic [i2cp_pkg::DATA_W-1:0] cmd_data_i,
   // Result
   output logic done_o,
   output logic nack_o,
   output logic [i2cp_pkg::DATA_W-1:0] rd_data_o
);
   import i2cp_pkg::*;
   typedef enum logic [4:0] {
      HS_IDLE = 5'h01,
      HS_START = 5'h02,
      HS_WBIT = 5'h04,
      HS_RBIT = 5'h08,
      HS_STOP = 5'h10
   } i2cp_hst_e;
   i2cp_hst_e st_reg, st_next;
   logic [3:0] div_reg;   // Quarter-period divider
   logic [1:0] q_reg;     // Quarter within bit
   logic [3:0] bit_reg, bit_next;
   logic [2:0] bidx_reg, bidx_next;
   logic [7:0] tx_reg, tx_next;
   logic [7:0] rx_reg, rx_next;
   logic rd_reg, rd_next;
   logic [6:0] dev_reg, dev_next;
   logic [15:0] adr_reg, adr_next;
   logic [7:0] dat_reg, dat_next;
   logic scl_reg, scl_next;
   logic oe_reg, oe_next;
   logic rdy_next, done_next, nack_next;
   logic [7:0] rdo_next;
   logic s1_reg, s2_reg;  // Data line synchroniser
   wire tick_w = div_reg == QTR_LAST;
   // Byte to send at a sequence position
   function automatic logic [7:0] byte_sel(input logic [2:0] idx);
      unique case (idx)
         HB_DEVW: byte_sel = {dev_reg, RW_WRITE};
         HB_HI: byte_sel = adr_reg[15:8];
         HB_LO: byte_sel = adr_reg[7:0];
         HB_DATA: byte_sel = dat_reg;
         default: byte_sel = {dev_reg, RW_READ};
      endcase
   endfunction : byte_sel
   // Sequencer next state
   always_comb
   begin
      st_next = st_reg;
      bit_next = bit_reg;
      bidx_next = bidx_reg;
      tx_next = tx_reg;
      rx_next = rx_reg;
      rd_next = rd_reg;
      dev_next = dev_reg;
      adr_next = adr_reg;
      dat_next = dat_reg;
      scl_next = scl_reg;
      oe_next = oe_reg;
      rdy_next = cmd_ready_o;
      done_next = 1'b0;
      nack_next = nack_o;
      rdo_next = rd_data_o;
      unique case (st_reg)
         HS_IDLE:
         begin
            if (cmd_valid_i)
            begin
               // Take command
               st_next = HS_START;
               rdy_next = 1'b0;
               nack_next = 1'b0;
               rd_next = cmd_rd_i;
               dev_next = cmd_dev_i;
               adr_next = cmd_addr_i;
               dat_next = cmd_data_i;
               bidx_next = HB_DEVW;
            end
         end
         HS_START:
         begin
            if (tick_w)
            begin
               // Restart drops clock first; a first start keeps the idle clock high
               unique case (q_reg)
                  Q_FALL: scl_next = bidx_reg == HB_DEVW;
                  Q_DRIVE: oe_next = 1'b0;
                  Q_RISE: scl_next = 1'b1;
                  Q_SAMPLE:
                  begin
                     oe_next = 1'b1;
                     st_next = HS_WBIT;
                     bit_next = '0;
                     tx_next = byte_sel(bidx_reg);
                  end
               endcase
            end
         end
         HS_WBIT:
         begin
            if (tick_w)
            begin
               unique case (q_reg)
                  Q_FALL: scl_next = 1'b0;
                  Q_DRIVE: oe_next = (bit_reg != BITS_PER_BYTE) && !tx_reg[7];
                  Q_RISE: scl_next = 1'b1;
                  Q_SAMPLE:
                  begin
                     bit_next = bit_reg + 4'h1;
                     tx_next = {tx_reg[6:0], 1'b0};
                     if (bit_reg == BITS_PER_BYTE)
                     begin
                        bit_next = '0;
                        if (s2_reg)
                        begin
                           // Target nack: give up
                           nack_next = 1'b1;
                           st_next = HS_STOP;
                        end
                        else if (bidx_reg == HB_LO && rd_reg)
                        begin
                           st_next = HS_START;
                           bidx_next = HB_DEVR;
                        end
                        else if (bidx_reg == HB_DEVR)
                           st_next = HS_RBIT;
                        else if (bidx_reg == HB_DATA)
                           st_next = HS_STOP;
                        else
                        begin
                           bidx_next = bidx_reg + 3'h1;
                           tx_next = byte_sel(bidx_reg + 3'h1);
                        end
                     end
                  end
               endcase
            end
         end
         HS_RBIT:
         begin
            if (tick_w)
            begin
               unique case (q_reg)
                  Q_FALL: scl_next = 1'b0;
                  Q_DRIVE: oe_next = 1'b0;
                  Q_RISE: scl_next = 1'b1;
                  Q_SAMPLE:
                  begin
                     bit_next = bit_reg + 4'h1;
                     if (bit_reg == BITS_PER_BYTE)
                        st_next = HS_STOP;
                     else
                        rx_next = {rx_reg[6:0], s2_reg};
                  end
               endcase
            end
         end
         HS_STOP:
         begin
            if (tick_w)
            begin
               unique case (q_reg)
                  Q_FALL: scl_next = 1'b0;
                  Q_DRIVE: oe_next = 1'b1;
                  Q_RISE: scl_next = 1'b1;
                  Q_SAMPLE:
                  begin
                     oe_next = 1'b0;
                     st_next = HS_IDLE;
                     rdy_next = 1'b1;
                     done_next = 1'b1;
                     rdo_next = rx_reg;
                  end
               endcase
            end
         end
      endcase
   end
   // Registers
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_reg <= HS_IDLE;
         div_reg <= '0;
         q_reg <= Q_FALL;
         bit_reg <= '0;
         bidx_reg <= HB_DEVW;
         {tx_reg, rx_reg, dat_reg, adr_reg} <= '0;
         rd_reg <= 1'b0;
         dev_reg <= '0;
         scl_reg <= 1'b1;
         oe_reg <= 1'b0;
         cmd_ready_o <= 1'b1;
         done_o <= 1'b0;
         nack_o <= 1'b0;
         rd_data_o <= '0;
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
         div_reg <= tick_w ? 4'h0 : div_reg + 4'h1;
         q_reg <= (st_reg == HS_IDLE) ? Q_FALL : q_reg + 2'(tick_w);
         bit_reg <= bit_next;
         bidx_reg <= bidx_next;
         {tx_reg, rx_reg, dat_reg, adr_reg} <= {tx_next, rx_next, dat_next, adr_next};
         rd_reg <= rd_next;
         dev_reg <= dev_next;
         scl_reg <= scl_next;
         oe_reg <= oe_next;
         cmd_ready_o <= rdy_next;
         done_o <= done_next;
         nack_o <= nack_next;
         rd_data_o <= rdo_next;
         s1_reg <= bus_if.sda_line;
         s2_reg <= s1_reg;
      end
   end
   assign bus_if.scl = scl_reg;
   assign bus_if.host_sda_o = 1'b0;
   assign bus_if.host_sda_oe = oe_reg;
endmodule : i2cp_host

//--- dv/i2cp_asserts.sv
`timescale 1ns/1ns
// Watches the shared serial lines between host and device ends
module i2cp_asserts
   import i2cp_pkg::*;
#(
   parameter logic [6:0] OWN_ADDR = DEV_ADDR
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // Serial lines
   input wire logic scl,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic sda_line
);
   logic scl_reg, sda_reg; // Line levels one cycle ago
   logic [3:0] cnt_reg; // Clock rises within the current byte frame since start, 1 to 9 then wraps to 1
   logic [6:0] sh_reg; // Last bits seen
   logic first_reg, rd_reg, mism_reg, nack_reg, idle_reg; // Transfer state
   wire rise = scl && !scl_reg;
   wire start = scl && scl_reg && sda_reg && !sda_line;
   wire stop = scl && scl_reg && !sda_reg && sda_line;
   wire ack_due = rise && cnt_reg == 4'h7 && first_reg && sh_reg == OWN_ADDR;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Frame tracker, restarted by every start
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         {scl_reg, sda_reg, idle_reg} <= 3'h7;
         {cnt_reg, sh_reg, first_reg, rd_reg, mism_reg, nack_reg} <= '0;
      end
      else
      begin
         scl_reg <= scl;
         sda_reg <= sda_line;
         if (start)
            {cnt_reg, first_reg, mism_reg, nack_reg, idle_reg} <= 8'h8;
         else if (stop)
            idle_reg <= 1'b1;
         else if (rise)
         begin
            cnt_reg <= (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
            sh_reg <= {sh_reg[5:0], sda_line};
            if (cnt_reg == 4'h7 && first_reg)
               {rd_reg, mism_reg} <= {sda_line, sh_reg != OWN_ADDR};
            if (cnt_reg == 4'h8)
               first_reg <= 1'b0;
            if (cnt_reg == 4'h8 && rd_reg && !first_reg && sda_line)
               nack_reg <= 1'b1;
         end
      end
   end
   // Acknowledge held for eight cycles after it is raised
   sequence hold_seq;
      dev_sda_oe [*8];
   endsequence
   stable_high_a: assert property (scl && scl_reg |-> $stable(dev_sda_oe))
      else $error("device data moved while clock high");
   change_low_a: assert property ($changed(dev_sda_oe) |-> !scl && !scl_reg)
      else $error("device data changed outside clock low");
   addr_ack_a: assert property (ack_due |-> ##[10:20] dev_sda_oe)
      else $error("own address not acknowledged");
   ack_hold_a: assert property ($rose(dev_sda_oe) && cnt_reg == 4'h8 |=> hold_seq)
      else $error("acknowledge not held");
   write_quiet_a: assert property (dev_sda_oe && !rd_reg |-> cnt_reg >= 4'h8)
      else $error("device drove outside acknowledge slot");
   mism_quiet_a: assert property (mism_reg |-> !dev_sda_oe)
      else $error("device answered another address");
   nack_quiet_a: assert property (nack_reg |-> !dev_sda_oe)
      else $error("device kept sending after nack");
   idle_quiet_a: assert property (idle_reg |-> !dev_sda_oe)
      else $error("device drove while bus idle");
   host_hold_a: assert property (scl && scl_reg && $changed(host_sda_oe) |-> start || stop)
      else $error("host data moved while clock high");
endmodule : i2cp_asserts

//--- dv/i2c_slave_register_port_test.sv
`timescale 1ns/1ns
// Host end talks to device end; bench checks results and stored bytes
module i2c_slave_register_port_test;
   import i2cp_pkg::*;
   logic ref_clk_i = 0, rst_b_i = 0, cmd_valid_i = 0, cmd_rd_i = 0, wr_ready_i = 0, stall = 0;
   logic [6:0] cmd_dev_i = 0;
   logic [15:0] cmd_addr_i = 0, ea = 0, b, wr_addr_o, rd_addr_o;
   logic [7:0] cmd_data_i = 0, d, wr_data_o, rd_data_o, rd_data_i;
   logic cmd_ready_o, done_o, nack_o, wr_valid_o;
   logic [7:0] lr = 0; // Last read byte expected, kept over a refused read
   logic [7:0] mem [0:255]; // User register file
   logic [7:0] emem [0:255]; // Expected register contents
   logic [25:0] q[$], e; // Expected {read, nack, data, address}
   logic [23:0] wq[$], w; // Expected stored {address, data}
   int bad_count = 0, cmp_count = 0, cyc = 0;
   i2cp_if bus ();
   i2cp_dev #(.OWN_ADDR(DEV_ADDR), .DEPTH(FIFO_DEPTH)) i2cp_dev_inst (.ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i), .bus_if(bus), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
      .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i));
   i2cp_host i2cp_host_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bus_if(bus),
      .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_rd_i(cmd_rd_i),
      .cmd_dev_i(cmd_dev_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
      .done_o(done_o), .nack_o(nack_o), .rd_data_o(rd_data_o));
   i2cp_asserts #(.OWN_ADDR(DEV_ADDR)) i2cp_asserts_inst (.ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i), .scl(bus.scl), .host_sda_o(bus.host_sda_o),
      .host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe),
      .sda_line(bus.sda_line));
   assign rd_data_i = mem[rd_addr_o[7:0]];
   // Clock
   initial forever #25 ref_clk_i = ~ref_clk_i;
   // Random stalls on the store side
   always @(negedge ref_clk_i) wr_ready_i <= !stall && 1'($urandom_range(1));
   // Compare and count
   task chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk
   // Verdict and end of run
   task results;
      if (bad_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results
   // One host command; expectation noted first
   task cmd(input logic r, input logic [6:0] v, input logic [15:0] a, input logic [7:0] x,
      input logic f);
      logic n;
      n = (v != DEV_ADDR) || f;
      if (v == DEV_ADDR)
         ea = a + (f ? 16'h0 : 16'h1);
      if (!n && !r)
      begin
         wq.push_back({a, x});
         emem[a[7:0]] = x;
      end
      if (r && !n)
         lr = emem[a[7:0]];
      q.push_back({r, n, lr, ea});
      @(negedge ref_clk_i);
      {cmd_valid_i, cmd_rd_i, cmd_dev_i, cmd_addr_i, cmd_data_i} = {1'b1, r, v, a, x};
      @(negedge ref_clk_i);
      cmd_valid_i = 1'b0;
      chk(32'(cmd_ready_o), 32'h0);
      for (int k = 0; k < 2000 && done_o !== 1'b1; k++)
         @(posedge ref_clk_i);
      chk(32'(done_o), 32'h1);
      @(negedge ref_clk_i);
   endtask : cmd
   // Result watcher, store watcher and hang limit
   always @(posedge ref_clk_i)
   begin
      if (done_o === 1'b1)
      begin
         e = q.pop_front();
         chk(32'(nack_o), 32'(e[24]));
         chk(32'(rd_addr_o), 32'(e[15:0]));
         if (e[25])
            chk(32'(rd_data_o), 32'(e[23:16]));
      end
      if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1)
      begin
         w = wq.pop_front();
         chk(32'({wr_addr_o, wr_data_o}), 32'(w));
         mem[wr_addr_o[7:0]] <= wr_data_o;
      end
      cyc++;
      if (cyc > 80000)
      begin
         bad_count++;
         results();
      end
   end
   // Main sequence
   initial
   begin
      void'($urandom(32'h9c6a));
      repeat (2) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      repeat (4)
      begin
         b = 16'($urandom);
         d = 8'($urandom);
         cmd(1'b0, DEV_ADDR, b, d, 1'b0);
         cmd(1'b1, DEV_ADDR, b, 8'h00, 1'b0);
      end
      cmd(1'b0, DEV_ADDR ^ 7'h01, 16'h1234, 8'h5a, 1'b0);
      cmd(1'b1, DEV_ADDR ^ 7'h40, 16'h1234, 8'h00, 1'b0);
      stall = 1'b1;
      for (int i = 0; i <= FIFO_DEPTH; i++)
         cmd(1'b0, DEV_ADDR, 16'h0100 + 16'(i), 8'(i * 7 + 3), i == FIFO_DEPTH);
      stall = 1'b0;
      repeat (60) @(posedge ref_clk_i);
      cmd(1'b1, DEV_ADDR, 16'h0103, 8'h00, 1'b0);
      chk(32'(q.size() + wq.size()), 32'h0);
      results();
   end
endmodule : i2c_slave_register_port_test
